// ### core/calendar_clock_core.sv
/*
 * Calendar clock core: bcd time, date, weekday, alarm with digit masks,
 * periodic tick, crystal trim, 80-byte spare store cleared by tamper.
 * Assumes an APB master on pclk, a 32 kHz square wave on lxt_pin and a
 * tamper level on tamper_pin, both asynchronous to pclk.
 */
// The placing of the registers and the APB interface to the registers were left to the implementer.
//
// Operation
// - idle in reset until start key written
// - running state is permanent once entered
// - start register bit 0 shows running
// - count hours minutes seconds year month day
// - all time fields held in bcd
// - programmable alarm compared against counters
// - per-digit alarm masks allow recurring alarms
// - hour counter on 12 or 24 scale
// - read-only leap year indication
// - weekday counter advances with the day
// - digital trim of crystal frequency error
// - tick at one of eight intervals
// - interrupt on tick and on alarm
// - interrupt also wakes the chip
// - 80 bytes of spare storage
// - tamper event clears spare storage
// - writes take effect after two slow clocks
// - access key opens writes for 1024 clocks
// - weekday 0 to 6 is Sunday to Saturday
// - alarm match sets flag, irq if enabled
`timescale 1ns/1ps
`include "calendar_clock_defines.svh"
module calendar_clock_core
   import calendar_clock_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        lxt_pin,
   input  wire logic        tamper_pin,
   output logic             irq,
   output logic             wake
);
   // ======================================================================
   // bcd helpers
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9)
         return {v[7:4] + 4'h1, 4'h0};
      return {v[7:4], v[3:0] + 4'h1};
   endfunction

   // returns {day carry, next hour}; 12-hour codes keep pm in bit 5
   function automatic logic [8:0] hr_inc(input logic [7:0] h,
                                         input logic       f24);
      if (f24)
         return (h == 8'h23) ? 9'h100 : {1'b0, bcd_inc(h)};
      if (h == 8'h11)
         return 9'h032;
      if (h == 8'h31)
         return 9'h112;
      if (h == 8'h12)
         return 9'h001;
      if (h == 8'h32)
         return 9'h021;
      return {1'b0, bcd_inc(h)};
   endfunction

   // two-digit year divisible by four
   function automatic logic is_leap(input logic [7:0] y);
      if (y[4])
         return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] month_len(input logic [4:0] m,
                                            input logic       lp);
      if (m == 5'h02)
         return lp ? 8'h29 : 8'h28;
      if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
         return 8'h30;
      return 8'h31;
   endfunction

   // ======================================================================
   // state
   logic        lxt_s1_r, lxt_s2_r, lxt_s3_r;
   logic        tmp_s1_r, tmp_s2_r, tmp_s3_r;
   logic        init_r, acc_r, fmt24_r, extra_r, pend_r, match_r;
   logic [9:0]  acc_cnt_r;
   logic [1:0]  pend_cnt_r, inten_r, sts_r, sprctl_r;
   logic [2:0]  wday_r, tsel_r;
   logic [5:0]  tamsk_r, camsk_r;
   logic [11:0] fadj_r;
   logic [15:0] sub_r;
   logic [14:0] free_r;
   logic [6:0]  frac_r;
   tod_t        tod_r, talm_r, tod_nxt;
   date_t       date_r, calm_r, date_nxt;
   pend_t       pend_r_d;
   logic [31:0] spr_r [`SPR_WORDS];
   logic [2:0]  wday_nxt;
   logic [8:0]  hr_step;
   logic [31:0] rd_nxt;
   logic        hit, day_adv, match;

   // ======================================================================
   // pin synchronisers; only the second stage and later are read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {lxt_s1_r, lxt_s2_r, lxt_s3_r} <= 3'h0;
         {tmp_s1_r, tmp_s2_r, tmp_s3_r} <= 3'h0;
      end else begin
         {lxt_s1_r, lxt_s2_r, lxt_s3_r} <= {lxt_pin, lxt_s1_r, lxt_s2_r};
         {tmp_s1_r, tmp_s2_r, tmp_s3_r} <= {tamper_pin, tmp_s1_r, tmp_s2_r};
      end
   end

   // one pulse per rising edge of the 32 kHz clock
   wire rtc_pulse = lxt_s2_r & ~lxt_s3_r;
   // tamper edge select: bit 0 enables, bit 1 picks the falling edge
   wire tamper_evt = sprctl_r[0] &
        (sprctl_r[1] ? (~tmp_s2_r & tmp_s3_r) : (tmp_s2_r & ~tmp_s3_r));

   // ======================================================================
   // apb decode; locked registers drop writes, and trim, alarm time and date, tick and spare ones also read as zero
   wire spr_hit  = (paddr >= `A_SPR_LO) && (paddr <= `A_SPR_HI) &&
                   (paddr[1:0] == 2'b00);
   wire [4:0] spr_idx = 5'((paddr - `A_SPR_LO) >> 2);
   wire free_reg = (paddr == `A_INIT) || (paddr == `A_RWEN) ||
                   (paddr == `A_FMT) || (paddr == `A_INTEN) ||
                   (paddr == `A_INTSTS);
   wire wr_ok    = hit && (free_reg || (acc_r && paddr != `A_LEAP));
   wire access   = psel & penable;
   wire wr_done  = access & pready & pwrite;
   // a write stalls the bus while the previous one still waits
   wire pready_nxt = access & ~pready & (~pwrite | ~pend_r);

   always_comb begin
      rd_nxt = 32'h0;
      hit    = 1'b1;
      if (paddr == `A_INIT)
         rd_nxt = {31'h0, init_r};
      else if (paddr == `A_RWEN)
         rd_nxt = {15'h0, acc_r, 16'h0};
      else if (paddr == `A_FADJ)
         rd_nxt = acc_r ? {20'h0, fadj_r} : 32'h0;
      else if (paddr == `A_TIME)
         rd_nxt = {10'h0, tod_r.hr, 1'b0, tod_r.mn, 1'b0, tod_r.sc};
      else if (paddr == `A_CAL)
         rd_nxt = {8'h0, date_r.yr, 3'h0, date_r.mo, 2'h0, date_r.dy};
      else if (paddr == `A_FMT)
         rd_nxt = {31'h0, fmt24_r};
      else if (paddr == `A_WDAY)
         rd_nxt = {29'h0, wday_r};
      else if (paddr == `A_TALM)
         rd_nxt = acc_r ? {10'h0, talm_r.hr, 1'b0, talm_r.mn, 1'b0,
                           talm_r.sc} : 32'h0;
      else if (paddr == `A_CALM)
         rd_nxt = acc_r ? {8'h0, calm_r.yr, 3'h0, calm_r.mo, 2'h0,
                           calm_r.dy} : 32'h0;
      else if (paddr == `A_TAMSK)
         rd_nxt = {26'h0, tamsk_r};
      else if (paddr == `A_CAMSK)
         rd_nxt = {26'h0, camsk_r};
      else if (paddr == `A_LEAP)
         rd_nxt = {31'h0, is_leap(date_r.yr)};
      else if (paddr == `A_INTEN)
         rd_nxt = {30'h0, inten_r};
      else if (paddr == `A_INTSTS)
         rd_nxt = {30'h0, sts_r};
      else if (paddr == `A_TICK)
         rd_nxt = acc_r ? {29'h0, tsel_r} : 32'h0;
      else if (paddr == `A_SPRCTL)
         rd_nxt = acc_r ? {30'h0, sprctl_r} : 32'h0;
      else if (spr_hit)
         rd_nxt = acc_r ? spr_r[spr_idx] : 32'h0;
      else
         hit = 1'b0;
   end

   // answer one cycle into the access phase, later while a write waits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= pready_nxt;
         prdata  <= pready_nxt && !pwrite ? rd_nxt : 32'h0;
         pslverr <= pready_nxt & ~hit;
      end
   end

   // ======================================================================
   // two slow clocks
   // writes are held and applied after two 32 kHz edges, like hardware
   // whose registers sit in the slow domain
   wire   commit = pend_r & rtc_pulse & (pend_cnt_r == `COMMIT_RTC - 2'd1);
   wire [31:0] wd = pend_r_d.data;
   wire [7:0]  wa = pend_r_d.addr;
   wire [4:0]  w_idx = 5'((wa - `A_SPR_LO) >> 2);
   wire   w_spr = commit && (wa >= `A_SPR_LO);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r     <= 1'b0;
         pend_cnt_r <= 2'h0;
         pend_r_d   <= '0;
      end else if (wr_done && wr_ok) begin
         pend_r     <= 1'b1;
         pend_cnt_r <= 2'h0;
         pend_r_d   <= pend_t'{addr: paddr, data: pwdata};
      end else if (commit) begin
         pend_r     <= 1'b0;
      end else if (pend_r && rtc_pulse) begin
         pend_cnt_r <= pend_cnt_r + 2'd1;
      end
   end

   // ======================================================================
   // start key and window
   // the start flag can only rise; the access window closes by itself
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_r    <= 1'b0;
         acc_r     <= 1'b0;
         acc_cnt_r <= 10'h0;
      end else begin
         if (commit && wa == `A_INIT && wd == `KEY_START)
            init_r <= 1'b1;
         if (commit && wa == `A_RWEN && wd[15:0] == `KEY_ACCESS) begin
            acc_r     <= 1'b1;
            acc_cnt_r <= 10'h0;
         end else if (acc_r && rtc_pulse) begin
            acc_cnt_r <= acc_cnt_r + 10'd1;
            if (acc_cnt_r == `ACCESS_LAST)
               acc_r <= 1'b0;
         end
      end
   end

   // ======================================================================
   // trimmed second
   // each second lasts 32761 + integer slow edges, plus one more edge
   // whenever the fraction sum reaches sixty
   wire [15:0] sec_len = `SEC_BASE + {12'h0, fadj_r[11:8]} + {15'h0, extra_r};
   wire        sec_evt = init_r & rtc_pulse & (sub_r == sec_len - 16'd1);
   wire [6:0]  frac_sum = frac_r + {1'b0, fadj_r[5:0]};
   // tick select
   // select 0 ticks once a second, select 7 every 1/128 second
   wire [14:0] tick_mask = 15'h7fff >> tsel_r;
   wire        tick_evt = init_r & rtc_pulse &
                          ((free_r & tick_mask) == tick_mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_r   <= 16'h0;
         free_r  <= 15'h0;
         frac_r  <= 7'h0;
         extra_r <= 1'b0;
      end else if (init_r && rtc_pulse) begin
         free_r <= free_r + 15'd1;
         sub_r  <= sec_evt ? 16'h0 : sub_r + 16'd1;
         if (sec_evt) begin
            extra_r <= frac_sum >= `FRAC_WRAP;
            frac_r  <= frac_sum >= `FRAC_WRAP ? frac_sum - `FRAC_WRAP
                                              : frac_sum;
         end
      end
   end

   // ======================================================================
   // bcd time of day
   always_comb begin
      tod_nxt  = tod_r;
      date_nxt = date_r;
      wday_nxt = wday_r;
      hr_step  = hr_inc({2'b0, tod_r.hr}, fmt24_r);
      day_adv  = 1'b0;
      if (sec_evt) begin
         tod_nxt.sc = 7'(bcd_inc({1'b0, tod_r.sc}));
         if (tod_r.sc == 7'h59) begin
            tod_nxt.sc = 7'h00;
            tod_nxt.mn = 7'(bcd_inc({1'b0, tod_r.mn}));
            if (tod_r.mn == 7'h59) begin
               tod_nxt.mn = 7'h00;
               tod_nxt.hr = hr_step[5:0];
               day_adv    = hr_step[8];
            end
         end
      end
      if (day_adv) begin
         wday_nxt = (wday_r == 3'd6) ? 3'd0 : wday_r + 3'd1;
         date_nxt.dy = 6'(bcd_inc({2'b0, date_r.dy}));
         if ({2'b0, date_r.dy} == month_len(date_r.mo, is_leap(date_r.yr)))
         begin
            date_nxt.dy = 6'h01;
            date_nxt.mo = 5'(bcd_inc({3'b0, date_r.mo}));
            if (date_r.mo == 5'h12) begin
               date_nxt.mo = 5'h01;
               date_nxt.yr = date_r.yr == 8'h99 ? 8'h00 : bcd_inc(date_r.yr);
            end
         end
      end
   end

   // counters; a committed write replaces the counted value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tod_r  <= '0;
         date_r <= date_t'(`DATE_RST);
         wday_r <= 3'd0;
      end else begin
         tod_r  <= commit && wa == `A_TIME ?
                   tod_t'({wd[21:16], wd[14:8], wd[6:0]}) : tod_nxt;
         date_r <= commit && wa == `A_CAL ?
                   date_t'({wd[23:16], wd[12:8], wd[5:0]}) : date_nxt;
         wday_r <= commit && wa == `A_WDAY ? wd[2:0] : wday_nxt;
      end
   end

   // ======================================================================
   // control registers written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fadj_r   <= `FADJ_RST;
         fmt24_r  <= `FMT24_RST;
         talm_r   <= '0;
         calm_r   <= '0;
         tamsk_r  <= 6'h0;
         camsk_r  <= 6'h0;
         inten_r  <= 2'h0;
         tsel_r   <= 3'h0;
         sprctl_r <= 2'h0;
      end else if (commit) begin
         if (wa == `A_FADJ)
            fadj_r <= {wd[11:8], 2'b00, wd[5:0]};
         if (wa == `A_FMT)
            fmt24_r <= wd[0];
         if (wa == `A_TALM)
            talm_r <= tod_t'({wd[21:16], wd[14:8], wd[6:0]});
         if (wa == `A_CALM)
            calm_r <= date_t'({wd[23:16], wd[12:8], wd[5:0]});
         if (wa == `A_TAMSK)
            tamsk_r <= wd[5:0];
         if (wa == `A_CAMSK)
            camsk_r <= wd[5:0];
         if (wa == `A_INTEN)
            inten_r <= wd[1:0];
         if (wa == `A_TICK)
            tsel_r <= wd[2:0];
         if (wa == `A_SPRCTL)
            sprctl_r <= wd[1:0];
      end
   end

   // ======================================================================
   // masked digit compare
   // twelve nibbles; a set mask bit drops that digit from the compare
   wire [47:0] cur_dig = {date_r.yr, 3'h0, date_r.mo, 2'h0, date_r.dy,
                          2'h0, tod_r.hr, 1'b0, tod_r.mn, 1'b0, tod_r.sc};
   wire [47:0] alm_dig = {calm_r.yr, 3'h0, calm_r.mo, 2'h0, calm_r.dy,
                          2'h0, talm_r.hr, 1'b0, talm_r.mn, 1'b0, talm_r.sc};
   wire [11:0] dig_msk = {camsk_r, tamsk_r};

   always_comb begin
      match = init_r;
      for (int i = 0; i < 12; i++) begin
         if (!dig_msk[i] && cur_dig[4*i +: 4] != alm_dig[4*i +: 4])
            match = 1'b0;
      end
   end

   // sticky flags
   // write one clears, but an event in the same cycle wins
   wire       alm_evt = match & ~match_r;
   wire [1:0] sts_clr = (commit && wa == `A_INTSTS) ? wd[1:0] : 2'h0;
   wire [1:0] sts_nxt = (sts_r & ~sts_clr) | {tick_evt, alm_evt};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_r <= 1'b0;
         sts_r   <= 2'h0;
         irq     <= 1'b0;
         wake    <= 1'b0;
      end else begin
         match_r <= match;
         sts_r   <= sts_nxt;
         irq     <= |(sts_nxt & inten_r);
         wake    <= |(sts_nxt & inten_r);
      end
   end

   // ======================================================================
   // spare words
   // tamper beats a write landing in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `SPR_WORDS; i++)
            spr_r[i] <= 32'h0;
      end else if (tamper_evt) begin
         for (int i = 0; i < `SPR_WORDS; i++)
            spr_r[i] <= 32'h0;
      end else if (w_spr) begin
         spr_r[w_idx] <= wd;
      end
   end

   // ======================================================================
   // checks
   a_init_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      init_r |=> init_r [*4])
      else $error("running state was left");
   a_idle_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !init_r && !commit |=> $stable(tod_r) && $stable(date_r))
      else $error("time advanced before start key");
   a_init_read: assert property (@(posedge pclk) disable iff (!presetn)
      pready_nxt && !pwrite && paddr == `A_INIT && $stable(init_r)
      |=> prdata[0] == $past(init_r))
      else $error("start bit readback wrong");
   a_commit_late: assert property (@(posedge pclk) disable iff (!presetn)
      commit |-> $past(pend_r, 2))
      else $error("write applied too early");
   a_access_hold: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(acc_r) |-> $past(acc_cnt_r) == `ACCESS_LAST)
      else $error("access window closed early");
   a_wday_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      day_adv && wday_r == 3'd6 && !commit |=> wday_r == 3'd0)
      else $error("weekday did not wrap");
   a_alarm_flag: assert property (@(posedge pclk) disable iff (!presetn)
      match && !match_r ##1 inten_r[0] |-> sts_r[0] ##1 irq)
      else $error("alarm flag or irq missing");
   a_tick_flag: assert property (@(posedge pclk) disable iff (!presetn)
      tick_evt |=> sts_r[1])
      else $error("tick flag not set");
   a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      sts_r == 2'h0 && !tick_evt && !alm_evt |=> !irq)
      else $error("irq without a flag");
   a_tamper_wipe: assert property (@(posedge pclk) disable iff (!presetn)
      tamper_evt |=> spr_r[0] == 32'h0 && spr_r[19] == 32'h0)
      else $error("spare store not cleared");
   a_sec_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      sec_evt && tod_r.sc == 7'h59 && !commit
      |=> tod_r.sc == 7'h00)
      else $error("seconds did not wrap");
endmodule

// ### core/calendar_clock_defines.svh
/*
 * Register offsets, keys, reset values and counts of the calendar clock.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
`ifndef CALENDAR_CLOCK_DEFINES_SVH
`define CALENDAR_CLOCK_DEFINES_SVH
// ==========================================================================
// register byte offsets
`define A_INIT     8'h00
`define A_RWEN     8'h04
`define A_FADJ     8'h08
`define A_TIME     8'h0c
`define A_CAL      8'h10
`define A_FMT      8'h14
`define A_WDAY     8'h18
`define A_TALM     8'h1c
`define A_CALM     8'h20
`define A_LEAP     8'h24
`define A_INTEN    8'h28
`define A_INTSTS   8'h2c
`define A_TICK     8'h30
`define A_TAMSK    8'h34
`define A_CAMSK    8'h38
`define A_SPRCTL   8'h3c
`define A_SPR_LO   8'h40
`define A_SPR_HI   8'h8c
`define SPR_WORDS  20
// ==========================================================================
// keys, counts and reset values
`define KEY_START  32'ha5eb1357
`define KEY_ACCESS 16'ha965
`define ACCESS_LAST 10'h3ff
`define COMMIT_RTC 2'd2
`define SEC_BASE   16'd32761
`define FRAC_WRAP  7'd60
`define FADJ_RST   12'h700
`define FMT24_RST  1'b1
`define DATE_RST   19'h00041
`endif

// ### core/calendar_clock_pkg.sv
/*
 * Types shared by the calendar clock: time of day, date, pending write.
 * Assumes the defines header supplies all numeric constants.
 */
package calendar_clock_pkg;
   // ======================================================================
   // bcd time of day and date
   typedef struct packed {
      logic [5:0] hr;
      logic [6:0] mn;
      logic [6:0] sc;
   } tod_t;
   typedef struct packed {
      logic [7:0] yr;
      logic [4:0] mo;
      logic [5:0] dy;
   } date_t;
   // write waiting for the slow clock
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
   } pend_t;
endpackage

// ### testbench/calendar_clock_core_tb.sv
/*
 * Self-checking bench of the calendar clock core over APB.
 * Assumes the defines header and package of the core; lxt is driven fast.
 */
`timescale 1ns/1ps
`include "calendar_clock_defines.svh"
module calendar_clock_core_tb
   import calendar_clock_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite;
   logic        lxt_pin, tamper_pin, pready, pslverr, irq, wake, err_q;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_q;
   int          num_errors, tests_run, lxt_cnt, t0, sel, exp_per;

   calendar_clock_core calendar_clock_core_inst (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lxt_pin(lxt_pin), .tamper_pin(tamper_pin), .irq(irq), .wake(wake));

   // ======================================================================
   // clocks: lxt toggles every 3 pclk, slower than the toggle every pclk the core tolerates
   // bus and slow clocks
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      lxt_pin = 1'b0;
      forever begin
         repeat (3) @(posedge pclk);
         lxt_pin <= ~lxt_pin;
      end
   end
   always @(posedge lxt_pin) lxt_cnt++;

   // ======================================================================
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen at a rising
   // edge, and the answer is taken at that same edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         num_errors++;
         stop_test();
      end
      rd_q  = prdata;
      err_q = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask
   // a write lands two lxt edges later plus the synchroniser; the extra
   // cycles let irq, which follows an enable write one clock late, settle too
   task automatic settle();
      repeat (2) @(posedge lxt_pin);
      repeat (8) @(posedge pclk);
   endtask
   task automatic open_win();
      wr(`A_RWEN, {16'h0, `KEY_ACCESS});
      settle();
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 30000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 30000) begin
         num_errors++;
         stop_test();
      end
   endtask

   // ======================================================================
   // scenarios
   task automatic t_reset();
      rd(`A_INIT);  chk(rd_q, 32'h0);
      rd(`A_FMT);   chk(rd_q, 32'h1);
      rd(`A_CAL);   chk(rd_q, 32'h101);
      rd(`A_FADJ);  chk(rd_q, 32'h0);
      rd(8'h90);    chk(err_q, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_start();
      wr(`A_INIT, 32'ha5eb1356); settle();
      rd(`A_INIT);  chk(rd_q, 32'h0);
      wr(`A_INIT, `KEY_START); settle();
      rd(`A_INIT);  chk(rd_q[0], 1'b1);
      wr(`A_INIT, 32'h0); settle();
      rd(`A_INIT);  chk(rd_q[0], 1'b1);
      $display("test start done");
   endtask
   task automatic t_window();
      wr(`A_WDAY, 32'h5); settle();
      rd(`A_WDAY);  chk(rd_q, 32'h0);
      open_win();
      rd(`A_RWEN);  chk(rd_q[16], 1'b1);
      wr(`A_WDAY, 32'h6);
      rd(`A_WDAY);  chk(rd_q, 32'h0);
      settle();
      rd(`A_WDAY);  chk(rd_q, 32'h6);
      wr(`A_FADJ, 32'hc27); settle();
      rd(`A_FADJ);  chk(rd_q, 32'hc27);
      repeat (990) @(posedge lxt_pin);
      rd(`A_RWEN);  chk(rd_q[16], 1'b1);
      repeat (40) @(posedge lxt_pin);
      rd(`A_RWEN);  chk(rd_q[16], 1'b0);
      rd(`A_FADJ);  chk(rd_q, 32'h0);
      $display("test window done");
   endtask
   task automatic t_calendar();
      open_win();
      wr(`A_TIME, 32'h00123456);
      wr(`A_CAL, 32'h00240229); settle();
      rd(`A_TIME);  chk(rd_q, 32'h00123456);
      rd(`A_LEAP);  chk(rd_q[0], 1'b1);
      wr(`A_LEAP, 32'h0); settle();
      rd(`A_LEAP);  chk(rd_q[0], 1'b1);
      wr(`A_CAL, 32'h00230301); settle();
      rd(`A_LEAP);  chk(rd_q[0], 1'b0);
      wr(`A_FMT, 32'h0); settle();
      rd(`A_FMT);   chk(rd_q, 32'h0);
      wr(`A_FMT, 32'h1);
      $display("test calendar done");
   endtask
   // alarm hour differs, so only the hour mask makes it match
   task automatic t_alarm();
      open_win();
      wr(`A_TALM, 32'h00113456);
      wr(`A_CALM, 32'h00230301);
      wr(`A_INTEN, 32'h1);
      wr(`A_INTSTS, 32'h3); settle();
      rd(`A_INTSTS); chk(rd_q[0], 1'b0);
      wr(`A_TAMSK, 32'h30); settle();
      rd(`A_INTSTS); chk(rd_q[0], 1'b1);
      chk(irq, 1'b1);
      chk(wake, 1'b1);
      wr(`A_INTEN, 32'h0); settle();
      chk(irq, 1'b0);
      rd(`A_INTSTS); chk(rd_q[0], 1'b1);
      wr(`A_INTSTS, 32'h1); settle();
      rd(`A_INTSTS); chk(rd_q[0], 1'b0);
      $display("test alarm done");
   endtask
   // tick period measured irq rise to irq rise, in lxt edges
   task automatic t_tick();
      for (sel = 7; sel >= 5; sel--) begin
         open_win();
         wr(`A_INTEN, 32'h2);
         wr(`A_TICK, sel); settle();
         wr(`A_INTSTS, 32'h2); settle();
         wait_irq();
         t0 = lxt_cnt;
         wr(`A_INTSTS, 32'h2); settle();
         chk(irq, 1'b0);
         wait_irq();
         exp_per = 1 << (15 - sel);
         chk(lxt_cnt - t0 inside {[exp_per - 2:exp_per + 2]}, 1'b1);
      end
      wr(`A_INTEN, 32'h0);
      $display("test tick done");
   endtask
   task automatic t_spare();
      open_win();
      wr(`A_SPRCTL, 32'h1);
      wr(`A_SPR_LO, 32'hdeadbeef);
      wr(`A_SPR_HI, 32'h12345678); settle();
      rd(`A_SPR_LO); chk(rd_q, 32'hdeadbeef);
      rd(`A_SPR_HI); chk(rd_q, 32'h12345678);
      @(posedge pclk);
      tamper_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(`A_SPR_LO); chk(rd_q, 32'h0);
      rd(`A_SPR_HI); chk(rd_q, 32'h0);
      $display("test spare done");
   endtask

   // ======================================================================
   // verdict, main sequence and watchdog
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; tamper_pin = 1'b0;
      num_errors = 0; tests_run = 0; lxt_cnt = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_start();
      t_window();
      t_calendar();
      t_alarm();
      t_tick();
      t_spare();
      stop_test();
   end
   // whole run is under 30k pclk; three times that means a hang
   initial begin
      repeat (90000) @(posedge pclk);
      num_errors++;
      stop_test();
   end
endmodule
